// >>> hw/ssb_core.sv
// Synchronous serial port core: shift register, receive buffer and flags.
//
// Function
// - Mode bits pick master or slave clocking.
// - Clock polarity sets idle serial clock level.
// - Sample phase: middle or end of bit.
// - Clock edge setting picks output change edge.
// - Rate selection applies only as master.
// - Select-qualified mode exists only as slave.
// - Shift eight bits, most significant first.
// - After eight bits, buffer byte, set flags.
// - Next byte may start before buffer read.
// - Writes during transfer dropped, collision flag set.
// - Buffer read clears the buffer-full flag unless a queued byte refills the buffer.
// - Shift register reached only through buffer.
// - Interrupt flag sets regardless of enables.
`default_nettype none
module ssb_core #(
  parameter int unsigned FIFO_DEPTH = ssb_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Configuration
  input wire logic [3:0] mode_sel,
  input wire logic clk_pol,
  input wire logic clk_edge,
  input wire logic sample_end,
  input wire logic port_en,
  // Software buffer access
  input wire logic buf_wr,
  input wire logic [7:0] buf_wdata,
  input wire logic buf_rd,
  output logic [7:0] serial_xfer_buffer,
  // Flags
  output logic buffer_full_flag,
  output logic write_collision_flag,
  input wire logic write_collision_flag_clr,
  output logic serial_port_irq_flag,
  input wire logic irq_clr,
  output logic busy,
  // Serial pins
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  input wire logic ss_n_in
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic sck_prev_q;
  logic [1:0] warm_q;
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_q <= 3'h7;
      sync2_q <= 3'h7;
      sck_prev_q <= 1'b0;
      warm_q <= 2'h0;
    end
    else
    begin
      sync1_q <= {ss_n_in, sdi, sck_in};
      sync2_q <= sync1_q;
      sck_prev_q <= sync2_q[0];
      warm_q <= warm_q + 2'(warm_q != 2'h3);
    end
  end
  // Clock edges count only once the chain holds real pin values, so reset leaves no false edge.
  wire sync_ok = (warm_q == 2'h3);
  wire sck_s = sync2_q[0];
  wire sdi_s = sync2_q[1];
  wire ss_n_s = sync2_q[2];

  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  wire is_master = port_en && (mode_sel == ssb_pkg::MODE_MASTER_DIV4 || mode_sel == ssb_pkg::MODE_MASTER_DIV16
                   || mode_sel == ssb_pkg::MODE_MASTER_DIV64);
  wire is_slave = port_en && (mode_sel == ssb_pkg::MODE_SLAVE || mode_sel == ssb_pkg::MODE_SLAVE_SS);
  wire ss_mode = is_slave && (mode_sel == ssb_pkg::MODE_SLAVE_SS);
  wire slave_on = is_slave && !(ss_mode && ss_n_s);
  wire [5:0] half_per = (mode_sel == ssb_pkg::MODE_MASTER_DIV16) ? ssb_pkg::HALF_DIV16 :
                        (mode_sel == ssb_pkg::MODE_MASTER_DIV64) ? ssb_pkg::HALF_DIV64 :
                        ssb_pkg::HALF_DIV4;
  // Leading and trailing edges of the slave's incoming clock, relative to idle level.
  wire sck_rise = sync_ok && sck_s && !sck_prev_q;
  wire sck_fall = sync_ok && !sck_s && sck_prev_q;
  wire s_lead = slave_on && (clk_pol ? sck_fall : sck_rise);
  wire s_trail = slave_on && (clk_pol ? sck_rise : sck_fall);

  // ------------------------------------------------------------
  // Shift engine
  // ------------------------------------------------------------
  ssb_pkg::ssb_state_e st_q;
  ssb_pkg::ssb_state_e st_d;
  logic [7:0] serial_shift_reg_q;
  logic [3:0] bits_q;
  logic [5:0] div_q;
  logic sck_q;
  logic sdo_q;
  logic samp_q;
  logic active_q;
  logic ev_sample_q;
  logic done_q;
  wire div_hit = (div_q == half_per - 6'h01);
  wire m_lead = is_master && (st_q == ssb_pkg::SSB_LEAD) && div_hit;
  wire m_trail = is_master && (st_q == ssb_pkg::SSB_TRAIL) && div_hit;
  wire ev_lead = m_lead || s_lead;
  wire ev_trail = m_trail || s_trail;
  // With clk_edge set data changes on the trailing edge of the previous bit,
  // so the line is loaded before the first edge and, with sample_end clear, sampled on the lead.
  wire ev_sample = clk_edge ? (sample_end ? ev_trail : ev_lead) : (sample_end ? ev_lead : ev_trail);
  wire ev_shift = clk_edge ? ev_trail : ev_lead;
  // As master the data pin lags its own clock by the synchroniser, so sampling and completion wait one cycle.
  wire samp_now = is_master ? ev_sample_q : ev_sample;
  wire last_bit = (bits_q == ssb_pkg::BIT_COUNT - 4'h1);
  wire byte_done = is_master ? done_q : (ev_trail && last_bit);
  wire wr_collide = buf_wr && active_q;
  wire wr_ok = buf_wr && !active_q;
  wire m_start = wr_ok && is_master;
  wire s_start = (s_lead || s_trail) && !active_q;

  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      ssb_pkg::SSB_IDLE: if (m_start) st_d = ssb_pkg::SSB_LEAD;
      ssb_pkg::SSB_LEAD: if (m_lead) st_d = ssb_pkg::SSB_TRAIL;
      ssb_pkg::SSB_TRAIL: if (m_trail) st_d = last_bit ? ssb_pkg::SSB_IDLE : ssb_pkg::SSB_LEAD;
    endcase
    if (!is_master)
      st_d = ssb_pkg::SSB_IDLE;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= ssb_pkg::SSB_IDLE;
      div_q <= '0;
      sck_q <= 1'b0;
      ev_sample_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      ev_sample_q <= ev_sample && is_master;
      done_q <= m_trail && last_bit;
      div_q <= (st_q == ssb_pkg::SSB_IDLE || div_hit) ? 6'h00 : div_q + 6'h01;
      sck_q <= (st_d == ssb_pkg::SSB_TRAIL) ? !clk_pol : clk_pol;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      serial_shift_reg_q <= ssb_pkg::SHIFT_RST;
      bits_q <= '0;
      sdo_q <= 1'b0;
      samp_q <= 1'b0;
      active_q <= 1'b0;
    end
    else if (!(is_master || slave_on))
    begin
      bits_q <= '0;
      active_q <= 1'b0;
      // A deselected slave still takes its next byte from software.
      if (wr_ok)
      begin
        serial_shift_reg_q <= buf_wdata;
        sdo_q <= buf_wdata[7];
      end
    end
    else
    begin
      if (wr_ok)
      begin
        serial_shift_reg_q <= buf_wdata;
        sdo_q <= buf_wdata[7];
      end
      else if (ev_shift && !(clk_edge && last_bit))
      begin
        serial_shift_reg_q <= {serial_shift_reg_q[6:0], samp_q};
        sdo_q <= clk_edge ? serial_shift_reg_q[6] : serial_shift_reg_q[7];
      end
      if (samp_now)
        samp_q <= sdi_s;
      if (m_start || s_start)
        active_q <= 1'b1;
      else if (byte_done)
        active_q <= 1'b0;
      if (ev_trail)
        bits_q <= last_bit ? 4'h0 : bits_q + 4'h1;
    end
  end

  // The last sample must be merged in when the byte completes.
  wire [7:0] rx_byte = {serial_shift_reg_q[6:0], (samp_now ? sdi_s : samp_q)};

  // ------------------------------------------------------------
  // Receive FIFO and buffer
  // ------------------------------------------------------------
  ssb_fifo_if #(.WIDTH(ssb_pkg::DATA_W)) rxq ();
  assign rxq.wdata = rx_byte;
  assign rxq.wvalid = byte_done;
  // Buffer refills from the queue once software has read it.
  wire buf_load = rxq.rvalid && (!buffer_full_flag || buf_rd);
  assign rxq.rready = buf_load;

  ssb_fifo #(.WIDTH(ssb_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .fq(rxq.fifo)
  );

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      serial_xfer_buffer <= ssb_pkg::BUF_RST;
      buffer_full_flag <= 1'b0;
      write_collision_flag <= 1'b0;
      serial_port_irq_flag <= 1'b0;
    end
    else
    begin
      if (buf_load)
        serial_xfer_buffer <= rxq.rdata;
      if (buf_load)
        buffer_full_flag <= 1'b1;
      else if (buf_rd)
        buffer_full_flag <= 1'b0;
      if (wr_collide)
        write_collision_flag <= 1'b1;
      else if (write_collision_flag_clr)
        write_collision_flag <= 1'b0;
      if (buf_load)
        serial_port_irq_flag <= 1'b1;
      else if (irq_clr)
        serial_port_irq_flag <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  assign sck_out = is_master ? sck_q : clk_pol;
  assign sck_oe = is_master;
  assign sdo = sdo_q;
  assign sdo_oe = is_master || slave_on;
  assign busy = active_q;
endmodule
`default_nettype wire

// >>> hw/ssb_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`default_nettype none
module ssb_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Stream ports
  ssb_fifo_if.fifo fq
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  wire do_w = fq.wvalid && fq.wready;
  wire do_r = fq.rvalid && fq.rready;
  assign fq.wready = (cnt_q != (AW+1)'(DEPTH));
  assign fq.rvalid = (cnt_q != '0);
  assign fq.rdata = mem[rp_q];

  always_ff @(posedge clk_sys)
  begin
    if (do_w)
      mem[wp_q] <= fq.wdata;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (do_w)
        wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      if (do_r)
        rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(do_w) - (AW+1)'(do_r);
    end
  end
endmodule
`default_nettype wire

// >>> hw/ssb_fifo_if.sv
// Interface carrying the received-byte stream between core and FIFO.
`default_nettype none
interface ssb_fifo_if #(parameter int unsigned WIDTH = 8);
  logic [WIDTH-1:0] wdata;
  logic wvalid;
  logic wready;
  logic [WIDTH-1:0] rdata;
  logic rvalid;
  logic rready;
  modport fifo (input wdata, input wvalid, output wready, output rdata, output rvalid, input rready);
  modport core (output wdata, output wvalid, input wready, input rdata, input rvalid, output rready);
endinterface
`default_nettype wire

// >>> hw/ssb_pkg.sv
// Package with constants and types shared by the serial shift buffer core.
`default_nettype none
package ssb_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [3:0] BIT_COUNT = 4'h8;
  localparam logic [7:0] SHIFT_RST = 8'h00;
  localparam logic [7:0] BUF_RST = 8'h00;
  // Control register 1 field positions.
  localparam int unsigned CTL1_WRITE_COLLISION_FLAG_BIT = 7;
  localparam int unsigned CTL1_CKP_BIT = 4;
  localparam int unsigned CTL1_MODE_LSB = 0;
  // Status register field positions.
  localparam int unsigned STAT_SMP_BIT = 7;
  localparam int unsigned STAT_CKE_BIT = 6;
  localparam int unsigned STAT_BF_BIT = 0;
  // Mode field encodings.
  localparam logic [3:0] MODE_MASTER_DIV4 = 4'h0;
  localparam logic [3:0] MODE_MASTER_DIV16 = 4'h1;
  localparam logic [3:0] MODE_MASTER_DIV64 = 4'h2;
  localparam logic [3:0] MODE_SLAVE_SS = 4'h4;
  localparam logic [3:0] MODE_SLAVE = 4'h5;
  // Half serial clock periods, in system clock cycles, per master rate.
  localparam logic [5:0] HALF_DIV4 = 6'h02;
  localparam logic [5:0] HALF_DIV16 = 6'h08;
  localparam logic [5:0] HALF_DIV64 = 6'h20;
  typedef enum logic [1:0] {SSB_IDLE, SSB_LEAD, SSB_TRAIL} ssb_state_e;
endpackage
`default_nettype wire

// >>> verification/ssb_core_sva.sv
// Concurrent checks on the serial shift buffer core ports.
`default_nettype none
module ssb_core_sva (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Controls
  input wire logic [3:0] mode_sel,
  input wire logic clk_pol,
  input wire logic port_en,
  input wire logic buf_wr,
  input wire logic write_collision_flag_clr,
  input wire logic ss_n_in,
  // Status and pins
  input wire logic busy,
  input wire logic buffer_full_flag,
  input wire logic write_collision_flag,
  input wire logic serial_port_irq_flag,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic sdo_oe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  wire mstr = port_en && mode_sel <= ssb_pkg::MODE_MASTER_DIV64;
  sequence idle_cfg;
    (mstr && !busy && $stable(clk_pol) && $stable(mode_sel)) [*3];
  endsequence
  sequence ss_off;
    (port_en && mode_sel == ssb_pkg::MODE_SLAVE_SS && ss_n_in) [*4];
  endsequence
  a_write_collision_flag_on_busy: assert property (buf_wr && busy |=> write_collision_flag)
    else $error("busy write not flagged");
  a_write_collision_flag_sticky: assert property (write_collision_flag && !write_collision_flag_clr |=> write_collision_flag)
    else $error("collision flag dropped");
  a_irq_with_full: assert property ($rose(buffer_full_flag) |-> serial_port_irq_flag)
    else $error("full without irq");
  a_idle_sck_level: assert property (idle_cfg |-> sck_out == clk_pol)
    else $error("idle clock level");
  a_master_drive: assert property ((mstr && $stable(mode_sel)) [*2] |-> sck_oe)
    else $error("master clock not driven");
  a_ss_release: assert property (ss_off |-> !sdo_oe && !busy)
    else $error("deselected slave active");
  a_write_starts: assert property (buf_wr && !busy && mstr |=> busy)
    else $error("write did not start");
  a_busy_span: assert property ($rose(busy) && mode_sel == ssb_pkg::MODE_MASTER_DIV4
    |-> busy [*8] ##[20:30] !busy)
    else $error("transfer length");
endmodule
bind ssb_core ssb_core_sva chk_u (.clk_sys, .arst_n, .mode_sel, .clk_pol, .port_en, .buf_wr, .write_collision_flag_clr, .ss_n_in,
  .busy, .buffer_full_flag, .write_collision_flag, .serial_port_irq_flag, .sck_out, .sck_oe, .sdo_oe);
`default_nettype wire

// >>> verification/ssb_core_tb.sv
// Self-checking bench for the serial shift buffer core.
`default_nettype none
`define CHK(a, e, m) begin samples_checked++; if ((a) !== (e)) begin failures++; $display("CHECK FAILED t=%0t %s", $time, m); end end
module ssb_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, arst_n = 1'b0, clk_pol = 1'b0, clk_edge = 1'b0, buf_wr = 1'b0, buf_rd = 1'b0;
  logic write_collision_flag_clr = 1'b0, irq_clr = 1'b0, tb_sck = 1'b0, tb_sdi = 1'b0, ss_n_in = 1'b1, peer_cs_n = 1'b1;
  logic busy, sck_out, sck_oe, sdo, sdo_oe, peer_miso, buffer_full_flag, write_collision_flag, serial_port_irq_flag;
  logic [3:0] mode_sel = ssb_pkg::MODE_SLAVE;
  logic [7:0] buf_wdata = 8'h00, peer_tx = 8'h00, peer_rx, serial_xfer_buffer, txv, got;
  int failures, samples_checked;
  wire sck_line = sck_oe ? sck_out : tb_sck;
  wire sdi_line = peer_cs_n ? tb_sdi : peer_miso;
  ssb_core dut_u (.clk_sys, .arst_n, .mode_sel, .clk_pol, .clk_edge, .sample_end(1'b0), .port_en(1'b1), .buf_wr,
    .buf_wdata, .buf_rd, .serial_xfer_buffer, .buffer_full_flag, .write_collision_flag, .write_collision_flag_clr,
    .serial_port_irq_flag, .irq_clr, .busy, .sck_in(tb_sck), .sck_out, .sck_oe, .sdi(sdi_line), .sdo, .sdo_oe, .ss_n_in);
  ssb_peer peer_u (.sck(sck_line), .mosi(sdo), .cs_n(peer_cs_n), .miso(peer_miso), .cpol(clk_pol),
    .chg_lead(!clk_edge), .tx_byte(peer_tx), .rx_byte(peer_rx));
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic pulse_wr(input logic [7:0] d);
    buf_wdata <= d;
    buf_wr <= 1'b1;
    @(posedge clk_sys);
    buf_wr <= 1'b0;
  endtask
  task automatic wait_done();
    int n = 0;
    while ((busy !== 1'b0 || buffer_full_flag !== 1'b1) && n++ < 3000)
      @(negedge clk_sys);
    if (n > 3000)
    begin
      failures++;
      close_out();
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    // Every rate and every polarity and edge pairing, with a refused write mid-transfer.
    for (int i = 0; i < 4; i++)
    begin
      txv = 8'h81 + 8'(19 * i);
      @(posedge clk_sys);
      mode_sel <= (i == 3) ? ssb_pkg::MODE_MASTER_DIV4 : 4'(i);
      clk_pol <= i[0];
      clk_edge <= i[1];
      peer_tx <= 8'hc3 - 8'(i);
      repeat (4) @(posedge clk_sys);
      peer_cs_n <= 1'b0;
      @(posedge clk_sys);
      pulse_wr(txv);
      @(posedge clk_sys);
      pulse_wr(8'hff);
      repeat (2) @(negedge clk_sys);
      `CHK(write_collision_flag, 1'b1, "collision")
      wait_done();
      `CHK(serial_xfer_buffer, 8'hc3 - 8'(i), "rx byte")
      `CHK(peer_rx, txv, "tx byte")
      `CHK(serial_port_irq_flag, 1'b1, "irq")
      `CHK(write_collision_flag, 1'b1, "collision held")
      @(posedge clk_sys);
      peer_cs_n <= 1'b1;
      buf_rd <= 1'b1;
      write_collision_flag_clr <= 1'b1;
      irq_clr <= 1'b1;
      @(posedge clk_sys);
      buf_rd <= 1'b0;
      write_collision_flag_clr <= 1'b0;
      irq_clr <= 1'b0;
      repeat (2) @(negedge clk_sys);
      `CHK(buffer_full_flag, 1'b0, "full after read")
      `CHK(write_collision_flag, 1'b0, "collision cleared")
      `CHK(serial_port_irq_flag, 1'b0, "irq cleared")
      $display("master test %0d done", i);
    end
    @(posedge clk_sys);
    mode_sel <= ssb_pkg::MODE_SLAVE_SS;
    clk_pol <= 1'b0;
    clk_edge <= 1'b1;
    txv = 8'h96;
    repeat (4) @(posedge clk_sys);
    // Two frames: the first while deselected, the second selected.
    for (int f = 0; f < 2; f++)
    begin
      for (int b = 7; b >= 0; b--)
      begin
        tb_sdi = txv[b];
        #163 tb_sck = 1'b1;
        got[b] = sdo;
        #157 tb_sck = 1'b0;
      end
      tb_sdi = ~tb_sdi;
      @(negedge clk_sys);
      if (f == 0)
      begin
        `CHK(busy, 1'b0, "deselected busy")
        `CHK(sdo_oe, 1'b0, "deselected drive")
        @(posedge clk_sys);
        pulse_wr(8'h3c);
        ss_n_in <= 1'b0;
        #300;
      end
    end
    wait_done();
    @(posedge clk_sys);
    ss_n_in <= 1'b1;
    `CHK(serial_xfer_buffer, 8'h96, "slave rx")
    `CHK(got, 8'h3c, "slave tx")
    $display("slave test done");
    close_out();
  end
endmodule
`default_nettype wire

// >>> verification/ssb_peer.sv
// Behavioural serial peer that answers a master transfer.
`default_nettype none
module ssb_peer (
  // Serial pins
  input wire logic sck,
  input wire logic mosi,
  input wire logic cs_n,
  output logic miso,
  // Mode and data
  input wire logic cpol,
  input wire logic chg_lead,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh_q;
  initial miso = 1'b0;
  // A released line shows the inverse of its last bit.
  always @(posedge cs_n) miso = ~miso;
  always @(negedge cs_n)
  begin
    sh_q = chg_lead ? tx_byte : {tx_byte[6:0], 1'b0};
    if (!chg_lead) miso = tx_byte[7];
  end
  always @(sck)
  begin
    if (!cs_n && ((sck != cpol) != chg_lead)) rx_byte = {rx_byte[6:0], mosi};
    else if (!cs_n)
    begin
      miso = sh_q[7];
      sh_q = {sh_q[6:0], 1'b0};
    end
  end
endmodule
`default_nettype wire
